// ===== include/ccor_pkg.sv
// Purpose: Shared constants and types of the core operand registers
// Assumes: 8-bit special-function bus, 16-bit program addresses
// Notes: Bit addresses of bit-addressable registers equal byte + index
package ccor_pkg;
	// ------------------------------------------------------------------
	// Special-function addresses
	// ------------------------------------------------------------------
	localparam logic [7:0] CCOR_ADDR_SP = 8'h81;
	localparam logic [7:0] CCOR_ADDR_DPL = 8'h82;
	localparam logic [7:0] CCOR_ADDR_DPH = 8'h83;
	localparam logic [7:0] CCOR_ADDR_ACC = 8'he0;
	localparam logic [7:0] CCOR_ADDR_B = 8'hf0;
	localparam logic [7:0] CCOR_SFR_BASE = 8'h80;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] CCOR_RST_SP = 8'h07;
	localparam logic [7:0] CCOR_RST_DPL = 8'h00;
	localparam logic [7:0] CCOR_RST_DPH = 8'h00;
	localparam logic [7:0] CCOR_RST_ACC = 8'h00;
	localparam logic [7:0] CCOR_RST_B = 8'h00;

	// ------------------------------------------------------------------
	// Opcode fields
	// ------------------------------------------------------------------
	localparam logic [7:0] CCOR_OP_NOP = 8'h00;
	localparam logic [7:0] CCOR_OP_SPARE = 8'ha5;
	localparam int CCOR_RN_FLAG_BIT = 3;
	localparam logic [2:0] CCOR_IND_PAT = 3'h3;
	localparam int CCOR_PAGE_BITS = 11;
	localparam int CCOR_BANK_POS = 3;

	// Branch target selection
	typedef enum logic [1:0] {
		CCOR_BR_REL = 2'b00,
		CCOR_BR_PAGE = 2'b01,
		CCOR_BR_FULL = 2'b10,
		CCOR_BR_NONE = 2'b11
	} ccor_br_t;

	// Single-bit operation on a bit-addressable register
	typedef enum logic [1:0] {
		CCOR_BIT_READ = 2'b00,
		CCOR_BIT_CLR = 2'b01,
		CCOR_BIT_SET = 2'b10,
		CCOR_BIT_CPL = 2'b11
	} ccor_bitop_t;
endpackage

// ===== include/ccor_op_if.sv
// Purpose: Carrier between top and its operand and branch helpers
// Assumes: Helpers are purely combinational
// Notes: Top drives requests, helpers answer in the same cycle
interface ccor_op_if;
	import ccor_pkg::*;
	logic [7:0] opcode;
	logic [1:0] bank;
	logic [7:0] direct;
	logic [7:0] rel;
	logic [15:0] next_pc;
	logic [10:0] page_tgt;
	logic [15:0] full_tgt;
	ccor_br_t kind;
	logic [7:0] rn_addr;
	logic [7:0] ind_addr;
	logic is_rn;
	logic is_ind;
	logic dir_sfr;
	logic is_nop;
	logic [15:0] target;

	modport top(output opcode, bank, direct, rel, next_pc, page_tgt,
		full_tgt, kind, input rn_addr, ind_addr, is_rn, is_ind, dir_sfr,
		is_nop, target);
	modport dec(input opcode, bank, direct, output rn_addr, ind_addr,
		is_rn, is_ind, dir_sfr, is_nop);
	modport br(input rel, next_pc, page_tgt, full_tgt, kind,
		output target);
endinterface

// ===== logic/ccor_oper_dec.sv
// Purpose: Operand address decode for banked and indirect registers
// Assumes: Bank number comes from the status word select bits
// Notes: Purely combinational
module ccor_oper_dec (
	ccor_op_if.dec op
);
	import ccor_pkg::*;

	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	// Working register lives in the selected bank
	always_comb begin
		op.rn_addr = {3'h0, op.bank, op.opcode[2:0]};
		op.ind_addr = {3'h0, op.bank, 2'h0, op.opcode[0]};
		op.is_rn = op.opcode[CCOR_RN_FLAG_BIT];
		op.is_ind = (op.opcode[3:1] == CCOR_IND_PAT);
		op.dir_sfr = (op.direct >= CCOR_SFR_BASE);
		op.is_nop = (op.opcode == CCOR_OP_NOP) ||
			(op.opcode == CCOR_OP_SPARE);
	end
endmodule

// ===== logic/ccor_br_calc.sv
// Purpose: Branch destination arithmetic
// Assumes: next_pc is the address after the whole branch instruction
// Notes: Purely combinational, wraps modulo 64 kB
module ccor_br_calc (
	ccor_op_if.br op
);
	import ccor_pkg::*;

	logic [15:0] rel_ext;

	// ------------------------------------------------------------------
	// Target select
	// ------------------------------------------------------------------
	// Signed offset, page splice or full load
	always_comb begin
		rel_ext = {{8{op.rel[7]}}, op.rel};
		case (op.kind)
			CCOR_BR_REL: op.target = op.next_pc + rel_ext;
			CCOR_BR_PAGE: op.target = {op.next_pc[15:CCOR_PAGE_BITS],
				op.page_tgt};
			CCOR_BR_FULL: op.target = op.full_tgt;
			default: op.target = op.next_pc;
		endcase
	end
endmodule

// ===== logic/ccor_core_regs.sv
// Purpose: Core register set and operand addressing of the CPU core
// Assumes: One CPU clock, asynchronous active-low reset
// Notes: Registers answer on the internal special-function bus
module ccor_core_regs (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic [7:0] i_sfr_wdata,
	input wire logic i_sfr_rd,
	input wire logic [7:0] i_bit_addr,
	input wire logic i_bit_req,
	input wire ccor_pkg::ccor_bitop_t i_bit_op,
	input wire logic i_push,
	input wire logic i_pop,
	input wire logic i_ptr_load,
	input wire logic [15:0] i_ptr_value,
	input wire logic i_ptr_inc,
	input wire logic i_acc_load,
	input wire logic [7:0] i_acc_value,
	input wire logic i_b_load,
	input wire logic [7:0] i_b_value,
	input wire logic [7:0] i_opcode,
	input wire logic [1:0] i_bank_sel,
	input wire logic [7:0] i_direct_addr,
	input wire logic [7:0] i_rel_offset,
	input wire logic [15:0] i_next_pc,
	input wire logic [10:0] i_page_target,
	input wire logic [15:0] i_full_target,
	input wire ccor_pkg::ccor_br_t i_br_kind,
	output logic [7:0] o_sfr_rdata,
	output logic o_sfr_hit,
	output logic o_bit_value,
	output logic o_bit_hit,
	output logic [7:0] o_stack_top_pointer,
	output logic [15:0] o_data_pointer_full,
	output logic [7:0] o_main_arith_register,
	output logic [7:0] o_second_arith_register,
	output logic [7:0] o_bank_working_reg,
	output logic [7:0] o_indirect_pointer_reg,
	output logic o_op_is_rn,
	output logic o_op_is_ind,
	output logic o_direct_is_sfr,
	output logic o_op_is_nop,
	output logic [15:0] o_branch_target
);
	import ccor_pkg::*;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] stack_top_pointer;
		logic [7:0] data_ptr_low_byte;
		logic [7:0] data_ptr_high_byte;
		logic [7:0] main_arith_register;
		logic [7:0] second_arith_register;
		logic [7:0] rdata;
		logic hit;
		logic bit_value;
		logic bit_hit;
		logic [7:0] rn_addr;
		logic [7:0] ind_addr;
		logic is_rn;
		logic is_ind;
		logic dir_sfr;
		logic is_nop;
		logic [15:0] target;
	} ccor_state_t;

	localparam ccor_state_t CCOR_STATE_RST = '{
		stack_top_pointer: CCOR_RST_SP,
		data_ptr_low_byte: CCOR_RST_DPL,
		data_ptr_high_byte: CCOR_RST_DPH,
		main_arith_register: CCOR_RST_ACC,
		second_arith_register: CCOR_RST_B,
		rdata: 8'h00,
		hit: 1'b0,
		bit_value: 1'b0,
		bit_hit: 1'b0,
		rn_addr: 8'h00,
		ind_addr: 8'h00,
		is_rn: 1'b0,
		is_ind: 1'b0,
		dir_sfr: 1'b0,
		is_nop: 1'b0,
		target: 16'h0000
	};

	ccor_state_t state_ff;
	ccor_state_t nxt_state;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Apply one single-bit operation to a byte
	function automatic logic [7:0] bit_apply(input logic [7:0] val,
		input logic [2:0] idx, input ccor_bitop_t bop);
		logic [7:0] res;
		res = val;
		case (bop)
			CCOR_BIT_CLR: res[idx] = 1'b0;
			CCOR_BIT_SET: res[idx] = 1'b1;
			CCOR_BIT_CPL: res[idx] = ~val[idx];
			default: res = val;
		endcase
		return res;
	endfunction

	// True when a bit address falls in a given register byte
	function automatic logic bit_in(input logic [7:0] baddr,
		input logic [7:0] base);
		return baddr[7:3] == base[7:3];
	endfunction

	// ------------------------------------------------------------------
	// Operand and branch helpers
	// ------------------------------------------------------------------
	ccor_op_if op_if ();

	// Helper requests come straight from the core inputs
	assign op_if.opcode = i_opcode;
	assign op_if.bank = i_bank_sel;
	assign op_if.direct = i_direct_addr;
	assign op_if.rel = i_rel_offset;
	assign op_if.next_pc = i_next_pc;
	assign op_if.page_tgt = i_page_target;
	assign op_if.full_tgt = i_full_target;
	assign op_if.kind = i_br_kind;

	ccor_oper_dec u_dec (
		.op(op_if.dec)
	);

	ccor_br_calc u_br (
		.op(op_if.br)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	// Hardware updates first, bus writes override, bit ops last
	always_comb begin
		nxt_state = state_ff;

		// Operand decode results, registered for the core
		nxt_state.rn_addr = op_if.rn_addr;
		nxt_state.ind_addr = op_if.ind_addr;
		nxt_state.is_rn = op_if.is_rn;
		nxt_state.is_ind = op_if.is_ind;
		nxt_state.dir_sfr = op_if.dir_sfr;
		nxt_state.is_nop = op_if.is_nop;
		nxt_state.target = op_if.target;

		// Stack pointer moves up before the pushed byte lands, down on a pop
		if (i_push && !op_if.is_nop) begin
			nxt_state.stack_top_pointer =
				state_ff.stack_top_pointer + 8'h01;
		end else if (i_pop && !op_if.is_nop) begin
			nxt_state.stack_top_pointer =
				state_ff.stack_top_pointer - 8'h01;
		end

		// Pointer load or increment from the core
		if (i_ptr_load && !op_if.is_nop) begin
			nxt_state.data_ptr_high_byte = i_ptr_value[15:8];
			nxt_state.data_ptr_low_byte = i_ptr_value[7:0];
		end else if (i_ptr_inc && !op_if.is_nop) begin
			{nxt_state.data_ptr_high_byte, nxt_state.data_ptr_low_byte} =
				{state_ff.data_ptr_high_byte,
				state_ff.data_ptr_low_byte} + 16'h0001;
		end

		// Arithmetic results from the core
		if (i_acc_load && !op_if.is_nop) begin
			nxt_state.main_arith_register = i_acc_value;
		end
		if (i_b_load && !op_if.is_nop) begin
			nxt_state.second_arith_register = i_b_value;
		end

		// Bus write, page select never consulted
		if (i_sfr_wr) begin
			if (i_sfr_addr == CCOR_ADDR_SP) begin
				nxt_state.stack_top_pointer = i_sfr_wdata;
			end else if (i_sfr_addr == CCOR_ADDR_DPL) begin
				nxt_state.data_ptr_low_byte = i_sfr_wdata;
			end else if (i_sfr_addr == CCOR_ADDR_DPH) begin
				nxt_state.data_ptr_high_byte = i_sfr_wdata;
			end else if (i_sfr_addr == CCOR_ADDR_ACC) begin
				nxt_state.main_arith_register = i_sfr_wdata;
			end else if (i_sfr_addr == CCOR_ADDR_B) begin
				nxt_state.second_arith_register = i_sfr_wdata;
			end
		end

		// Bus read, registered, unmapped reads zero with no hit
		nxt_state.hit = 1'b0;
		nxt_state.rdata = 8'h00;
		if (i_sfr_rd) begin
			nxt_state.hit = 1'b1;
			if (i_sfr_addr == CCOR_ADDR_SP) begin
				nxt_state.rdata = state_ff.stack_top_pointer;
			end else if (i_sfr_addr == CCOR_ADDR_DPL) begin
				nxt_state.rdata = state_ff.data_ptr_low_byte;
			end else if (i_sfr_addr == CCOR_ADDR_DPH) begin
				nxt_state.rdata = state_ff.data_ptr_high_byte;
			end else if (i_sfr_addr == CCOR_ADDR_ACC) begin
				nxt_state.rdata = state_ff.main_arith_register;
			end else if (i_sfr_addr == CCOR_ADDR_B) begin
				nxt_state.rdata = state_ff.second_arith_register;
			end else begin
				nxt_state.hit = 1'b0;
			end
		end

		// Single-bit access to either accumulator
		nxt_state.bit_hit = 1'b0;
		nxt_state.bit_value = 1'b0;
		if (i_bit_req) begin
			if (bit_in(i_bit_addr, CCOR_ADDR_ACC)) begin
				nxt_state.bit_hit = 1'b1;
				nxt_state.bit_value =
					state_ff.main_arith_register[i_bit_addr[2:0]];
				nxt_state.main_arith_register = bit_apply(
					nxt_state.main_arith_register, i_bit_addr[2:0],
					i_bit_op);
			end else if (bit_in(i_bit_addr, CCOR_ADDR_B)) begin
				nxt_state.bit_hit = 1'b1;
				nxt_state.bit_value =
					state_ff.second_arith_register[i_bit_addr[2:0]];
				nxt_state.second_arith_register = bit_apply(
					nxt_state.second_arith_register, i_bit_addr[2:0],
					i_bit_op);
			end
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	// Whole state in one register
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_ff <= CCOR_STATE_RST;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// All outputs straight from the state register
	assign o_sfr_rdata = state_ff.rdata;
	assign o_sfr_hit = state_ff.hit;
	assign o_bit_value = state_ff.bit_value;
	assign o_bit_hit = state_ff.bit_hit;
	assign o_stack_top_pointer = state_ff.stack_top_pointer;
	assign o_data_pointer_full = {state_ff.data_ptr_high_byte,
		state_ff.data_ptr_low_byte};
	assign o_main_arith_register = state_ff.main_arith_register;
	assign o_second_arith_register = state_ff.second_arith_register;
	assign o_bank_working_reg = state_ff.rn_addr;
	assign o_indirect_pointer_reg = state_ff.ind_addr;
	assign o_op_is_rn = state_ff.is_rn;
	assign o_op_is_ind = state_ff.is_ind;
	assign o_direct_is_sfr = state_ff.dir_sfr;
	assign o_op_is_nop = state_ff.is_nop;
	assign o_branch_target = state_ff.target;
endmodule

// ===== verification/ccor_core_props.sv
// Purpose: Port-level properties of the core operand registers
// Assumes: One clock domain, reset active low
// Notes: Bound to ccor_core_regs from the testbench file
module ccor_core_props
	import ccor_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic i_sfr_rd,
	input wire logic i_bit_req,
	input wire logic i_push,
	input wire logic [7:0] i_opcode,
	input wire logic [1:0] i_bank_sel,
	input wire logic [7:0] i_direct_addr,
	input wire logic [7:0] i_rel_offset,
	input wire logic [15:0] i_next_pc,
	input wire logic [10:0] i_page_target,
	input wire logic [15:0] i_full_target,
	input wire ccor_pkg::ccor_br_t i_br_kind,
	input wire logic [7:0] o_sfr_rdata,
	input wire logic o_sfr_hit,
	input wire logic [7:0] o_stack_top_pointer,
	input wire logic [15:0] o_data_pointer_full,
	input wire logic [7:0] o_main_arith_register,
	input wire logic [7:0] o_second_arith_register,
	input wire logic [7:0] o_bank_working_reg,
	input wire logic [7:0] o_indirect_pointer_reg,
	input wire logic o_direct_is_sfr,
	input wire logic [15:0] o_branch_target
);
	timeunit 1ns;
	timeprecision 1ps;
	logic run;
	// Core strobes only act on a real opcode
	assign run = i_opcode != 8'h00 && i_opcode != 8'ha5;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	a_push_pre_inc: assert property (i_push && run &&
		!(i_sfr_wr && i_sfr_addr == 8'h81) |=>
		o_stack_top_pointer == $past(o_stack_top_pointer) + 8'h01)
		else $error("push did not step pointer up by one");
	a_spare_nop_holds: assert property (i_opcode == 8'ha5 &&
		!i_sfr_wr && !i_bit_req |=> $stable(o_stack_top_pointer) &&
		$stable(o_data_pointer_full) && $stable(o_main_arith_register)
		&& $stable(o_second_arith_register))
		else $error("spare opcode changed a register");
	a_direct_space_split: assert property (1'b1 |=>
		o_direct_is_sfr == $past(i_direct_addr[7]))
		else $error("direct space decode wrong");
	a_bank_reg_addr: assert property (1'b1 |=>
		o_bank_working_reg == {3'h0, $past(i_bank_sel),
		$past(i_opcode[2:0])})
		else $error("working register address wrong");
	a_ind_ptr_addr: assert property (1'b1 |=>
		o_indirect_pointer_reg == {3'h0, $past(i_bank_sel), 2'h0,
		$past(i_opcode[0])})
		else $error("indirect pointer address wrong");
	a_rel_target_sum: assert property (i_br_kind == CCOR_BR_REL |=>
		o_branch_target == $past(i_next_pc) +
		{{8{$past(i_rel_offset[7])}}, $past(i_rel_offset)})
		else $error("relative target wrong");
	a_page_target_keep: assert property (i_br_kind == CCOR_BR_PAGE |=>
		o_branch_target == {$past(i_next_pc[15:11]),
		$past(i_page_target)})
		else $error("page target wrong");
	a_full_target_load: assert property (i_br_kind == CCOR_BR_FULL |=>
		o_branch_target == $past(i_full_target))
		else $error("full target wrong");
	a_sp_read_back: assert property (i_sfr_rd &&
		i_sfr_addr == 8'h81 |=> o_sfr_hit &&
		o_sfr_rdata == $past(o_stack_top_pointer))
		else $error("stack pointer read wrong");
	// Main scenarios reached
	c_push: cover property (i_push && run);
	c_bit: cover property (i_bit_req);
	c_page: cover property (i_br_kind == CCOR_BR_PAGE);
endmodule

// ===== verification/testbench.sv
// Purpose: Self-checking bench of the core operand registers
// Assumes: Inputs change at rising edges by non-blocking assignment
// Notes: Expected values are worked out here from the register rules
module testbench
	import ccor_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_mclk, i_rst_b, i_sfr_wr, i_sfr_rd, i_bit_req, i_push, i_pop;
	logic i_ptr_load, i_ptr_inc, i_acc_load, i_b_load;
	logic [7:0] i_sfr_addr, i_sfr_wdata, i_bit_addr, i_acc_value;
	logic [7:0] i_b_value, i_opcode, i_direct_addr, i_rel_offset;
	logic [1:0] i_bank_sel;
	logic [15:0] i_ptr_value, i_next_pc, i_full_target, o_data_pointer_full;
	logic [10:0] i_page_target;
	ccor_bitop_t i_bit_op;
	ccor_br_t i_br_kind;
	logic [7:0] o_sfr_rdata, o_stack_top_pointer, o_main_arith_register;
	logic [7:0] o_second_arith_register, o_bank_working_reg;
	logic [7:0] o_indirect_pointer_reg, m, op;
	logic o_sfr_hit, o_bit_value, o_bit_hit, o_op_is_rn, o_op_is_ind;
	logic o_direct_is_sfr, o_op_is_nop, ob;
	logic [15:0] o_branch_target;
	int failures = 0;
	int num_checks = 0;
	ccor_core_regs ccor_core_regs_inst (.*);
	// Clock, 20 ns period
	initial begin
		i_mclk = 1'b0;
		forever #10 i_mclk = ~i_mclk;
	end
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic ck(input string n, input logic [15:0] e,
		input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic nx;
		@(posedge i_mclk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_sfr_addr <= a;
		i_sfr_wdata <= d;
		i_sfr_wr <= 1'b1;
		@(posedge i_mclk);
		i_sfr_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e,
		input logic h);
		@(posedge i_mclk);
		i_sfr_addr <= a;
		i_sfr_rd <= 1'b1;
		@(posedge i_mclk);
		i_sfr_rd <= 1'b0;
		#1;
		ck("rdata", {8'h00, e}, {8'h00, o_sfr_rdata});
		ck("hit", {15'h0, h}, {15'h0, o_sfr_hit});
	endtask
	task automatic stb(input logic [5:0] s);
		@(posedge i_mclk);
		{i_push, i_pop, i_ptr_load, i_ptr_inc, i_acc_load, i_b_load} <= s;
		@(posedge i_mclk);
		{i_push, i_pop, i_ptr_load, i_ptr_inc, i_acc_load, i_b_load} <= 6'h0;
		#1;
	endtask
	task automatic br(input ccor_br_t k, input logic [15:0] pc,
		input logic [7:0] r, input logic [10:0] pg, input logic [15:0] e);
		@(posedge i_mclk);
		i_br_kind <= k;
		i_next_pc <= pc;
		i_rel_offset <= r;
		i_page_target <= pg;
		i_full_target <= 16'hbeef;
		nx;
		ck("target", e, o_branch_target);
	endtask
	// Hang guard
	initial begin
		#40000;
		failures++;
		final_report;
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{i_sfr_wr, i_sfr_rd, i_bit_req, i_push, i_pop} = 5'h0;
		{i_ptr_load, i_ptr_inc, i_acc_load, i_b_load} = 4'h0;
		{i_sfr_addr, i_sfr_wdata, i_bit_addr, i_acc_value} = 32'h0;
		{i_b_value, i_direct_addr, i_rel_offset, i_bank_sel} = 26'h0;
		{i_ptr_value, i_next_pc, i_full_target, i_page_target} = 59'h0;
		i_opcode = 8'hc0;
		i_bit_op = CCOR_BIT_READ;
		i_br_kind = CCOR_BR_NONE;
		i_rst_b = 1'b0;
		repeat (8) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		rd(8'h81, 8'h07, 1'b1);
		rd(8'h82, 8'h00, 1'b1);
		rd(8'h83, 8'h00, 1'b1);
		rd(8'he0, 8'h00, 1'b1);
		rd(8'hf0, 8'h00, 1'b1);
		$display("reset values done");
		wr(8'h82, 8'h34);
		wr(8'h83, 8'h12);
		wr(8'he0, 8'ha5);
		wr(8'hf0, 8'h5a);
		wr(8'h84, 8'hff);
		rd(8'h84, 8'h00, 1'b0);
		rd(8'he0, 8'ha5, 1'b1);
		rd(8'hf0, 8'h5a, 1'b1);
		ck("data_pointer_full", 16'h1234, o_data_pointer_full);
		$display("register access done");
		wr(8'h81, 8'h7f);
		stb(6'h20);
		ck("sp", 16'h0080, {8'h00, o_stack_top_pointer});
		stb(6'h30);
		ck("sp", 16'h0081, {8'h00, o_stack_top_pointer});
		@(posedge i_mclk);
		i_opcode <= 8'ha5;
		stb(6'h3f);
		ck("sp", 16'h0081, {8'h00, o_stack_top_pointer});
		ck("data_pointer_full", 16'h1234, o_data_pointer_full);
		ck("acc", 16'h00a5, {8'h00, o_main_arith_register});
		ck("nop", 16'h0001, {15'h0, o_op_is_nop});
		@(posedge i_mclk);
		i_opcode <= 8'hc0;
		i_ptr_value <= 16'h00ff;
		i_acc_value <= 8'h80;
		i_b_value <= 8'h01;
		stb(6'h0b);
		stb(6'h04);
		ck("data_pointer_full", 16'h0100, o_data_pointer_full);
		ck("b", 16'h0001, {8'h00, o_second_arith_register});
		rd(8'h83, 8'h01, 1'b1);
		$display("stack and pointer done");
		m = 8'h80;
		for (int k = 0; k < 5; k++) begin
			ob = (k == 4) ? 1'b0 : m[3];
			@(posedge i_mclk);
			i_bit_addr <= (k == 4) ? 8'hf7 : 8'he3;
			i_bit_op <= (k == 4) ? CCOR_BIT_SET : ccor_bitop_t'(k);
			i_bit_req <= 1'b1;
			@(posedge i_mclk);
			i_bit_req <= 1'b0;
			#1;
			case (k)
				1: m[3] = 1'b0;
				2: m[3] = 1'b1;
				3: m[3] = ~m[3];
				default: ;
			endcase
			ck("bit", {15'h0, ob}, {15'h0, o_bit_value});
			ck("bhit", 16'h0001, {15'h0, o_bit_hit});
		end
		ck("acc", {8'h00, m}, {8'h00, o_main_arith_register});
		ck("b", 16'h0081, {8'h00, o_second_arith_register});
		$display("bit access done");
		for (int b = 0; b < 4; b++) begin
			op = b[1] ? 8'h07 : 8'h0e;
			@(posedge i_mclk);
			i_bank_sel <= b[1:0];
			i_opcode <= op;
			i_direct_addr <= b[0] ? 8'h80 : 8'h7f;
			nx;
			ck("rn", {8'h00, 3'h0, b[1:0], op[2:0]},
				{8'h00, o_bank_working_reg});
			ck("ind", {8'h00, 3'h0, b[1:0], 2'h0, op[0]},
				{8'h00, o_indirect_pointer_reg});
			ck("isind", {15'h0, ~op[3]}, {15'h0, o_op_is_ind});
			ck("isrn", {15'h0, op[3]}, {15'h0, o_op_is_rn});
			ck("sfr", {15'h0, b[0]}, {15'h0, o_direct_is_sfr});
		end
		$display("operand decode done");
		br(CCOR_BR_REL, 16'h0002, 8'hfc, 11'h0, 16'hfffe);
		br(CCOR_BR_REL, 16'hffff, 8'h01, 11'h0, 16'h0000);
		br(CCOR_BR_PAGE, 16'h7ffe, 8'h00, 11'h123, 16'h7923);
		br(CCOR_BR_FULL, 16'h0010, 8'h00, 11'h0, 16'hbeef);
		$display("branch targets done");
		final_report;
	end
endmodule

bind ccor_core_regs ccor_core_props ccor_core_props_inst (.*);
